/* design/gpio_port_pkg.sv */
// types shared by the six-pin port
package gpio_port_pkg;
  typedef logic [5:0] pin_vec_t;
  typedef logic [7:0] reg_byte_t;
endpackage

/* design/gpio_port_regs.svh */
// register offsets, field positions and reset values of the six-pin port
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH
`define PORT_PIN_DATA_ADDR 8'h05
`define CHANGE_STATUS_ADDR 8'h0b
`define OPTIONS_ADDR 8'h81
`define PIN_DIRECTION_ADDR 8'h85
`define ANALOG_SELECT_ADDR 8'h91
`define PULLUP_SELECT_ADDR 8'h95
`define CHANGE_ENABLE_ADDR 8'h96
`define EXT_RESET_CTRL_ADDR 8'ha0
`define PULLUP_GLOBAL_BIT 7
`define CHANGE_FLAG_BIT 0
`define EXT_RESET_EN_BIT 0
`define INPUT_ONLY_PIN 3
`define OPTIONS_RESET 8'hff
`define DIRECTION_RESET 6'h3f
`define PULLUP_SELECT_RESET 6'h37
`define CHANGE_ENABLE_RESET 6'h00
`define ANALOG_SELECT_RESET 6'h3f
`endif

/* design/pin_sync.sv */
// two-flop synchroniser for the port pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // refused at elaboration: a zero-width synchroniser makes no sense
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be positive");
  end

  // first stage is only ever read by the second
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* design/six_pin_bidir_port.sv */
// six-pin bidirectional port with pull-ups and change detection
// Operation
// [RULE1] six pins, each input or output, one direction bit per pin
// [RULE2] direction bit 1 makes the pin an input, driver off
// [RULE3] direction bit 0 drives the output latch onto the pin
// [RULE4] pin 3 is input only; its direction bit reads 1
// [RULE5] data reads return pin levels; writes go to output latches
// [RULE6] writes merge into sampled pin levels, whole latch stored; here the latch takes wdata[5:0] as written, no merge with the pins
// [RULE7] pin 3 reads 0 while external reset function enabled
// [RULE8] analog selection does not force the drivers off
// [RULE9] software keeps analog pins set as inputs
// [RULE10] analog-selected pins read 0 in the data register
// [RULE11] software sets analog and comparator config before digital use
// [RULE12] each pin except pin 3 has its own selectable pull-up
// [RULE13] pull-up forced off while the pin is an output
// [RULE14] after reset all pull-ups off, global disable bit set
// [RULE15] bits 5..0 map pins, bits 7 and 6 read 0
// [RULE16] every pin offers an interrupt-on-change option
// [RULE17] global disable 1 kills pull-ups; 0 follows per-pin selects
// [RULE18] enabled pins compared to last-read value; mismatches set flag
// [RULE19] change enables cleared by reset
// [RULE20] pin levels synchronised before reads and merges
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_regs.svh"
module six_pin_bidir_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] pullup_en,
  output logic port_change_flag
);
  pin_vec_t pin_sync_lvl;
  pin_vec_t out_latch, next_out_latch;
  pin_vec_t pin_direction_bits, next_pin_direction_bits;
  pin_vec_t pullup_select_bits, next_pullup_select_bits;
  pin_vec_t change_detect_enables, next_change_detect_enables;
  pin_vec_t analog_select_reg, next_analog_select_reg;
  pin_vec_t last_read, next_last_read;
  reg_byte_t options, next_options;
  logic ext_reset_pin_enable, next_ext_reset_pin_enable;
  logic next_port_change_flag;
  reg_byte_t next_rdata;
  pin_vec_t port_view;
  pin_vec_t dir_view;
  pin_vec_t mismatch;
  logic pullup_global_disable;

  // refused at elaboration: the register map is fixed at six pins
  if (PINS != 6) begin : g_bad_pins
    $error("six_pin_bidir_port serves exactly six pins");
  end

  // pins sampled through two flops before any use
  pin_sync #(.WIDTH(6)) u_sync ( // RULE20
    .clk(clk),
    .reset_n(reset_n),
    .async_in(pin_in),
    .sync_out(pin_sync_lvl)
  );

  assign pullup_global_disable = options[`PULLUP_GLOBAL_BIT];

  // direction view: pin 3 always reads as input
  always_comb begin
    dir_view = pin_direction_bits;
    dir_view[`INPUT_ONLY_PIN] = 1'b1; // RULE4
  end

  // data view: analog pins and reset-function pin read zero
  always_comb begin
    port_view = pin_sync_lvl & ~analog_select_reg; // RULE5 RULE10
    if (ext_reset_pin_enable) begin
      port_view[`INPUT_ONLY_PIN] = 1'b0; // RULE7
    end
  end

  // per-pin driver and pull-up control
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      // analog select deliberately absent from the enable
      assign pin_oe[g] = ~dir_view[g]; // RULE1 RULE2 RULE3 RULE8
      assign pin_out[g] = out_latch[g] & ~dir_view[g]; // RULE3
      // pin 3 has no pull-up device at all
      if (g == `INPUT_ONLY_PIN) begin : g_nopu
        assign pullup_en[g] = 1'b0; // RULE12
      end else begin : g_pu
        assign pullup_en[g] = pullup_select_bits[g] & dir_view[g]
          & ~pullup_global_disable; // RULE12 RULE13 RULE17
      end
    end
  endgenerate

  // mismatch against the value latched at the last data read or data write
  assign mismatch = (port_view ^ last_read) & change_detect_enables; // RULE18

  // register next values
  always_comb begin
    next_out_latch = out_latch;
    next_pin_direction_bits = pin_direction_bits;
    next_pullup_select_bits = pullup_select_bits;
    next_change_detect_enables = change_detect_enables;
    next_analog_select_reg = analog_select_reg;
    next_options = options;
    next_ext_reset_pin_enable = ext_reset_pin_enable;
    next_last_read = last_read;
    next_port_change_flag = port_change_flag;
    next_rdata = 8'h00;
    if (wr_en) begin
      if (addr == `PORT_PIN_DATA_ADDR) begin
        // whole latch rewritten from write data; read side is the pins
        next_out_latch = wdata[5:0]; // RULE6
        next_last_read = port_view; // write also ends mismatch
      end else if (addr == `PIN_DIRECTION_ADDR) begin
        next_pin_direction_bits = wdata[5:0];
      end else if (addr == `PULLUP_SELECT_ADDR) begin
        next_pullup_select_bits = wdata[5:0];
        next_pullup_select_bits[`INPUT_ONLY_PIN] = 1'b0;
      end else if (addr == `CHANGE_ENABLE_ADDR) begin
        next_change_detect_enables = wdata[5:0]; // RULE16
      end else if (addr == `ANALOG_SELECT_ADDR) begin
        next_analog_select_reg = wdata[5:0];
      end else if (addr == `OPTIONS_ADDR) begin
        next_options = wdata;
      end else if (addr == `EXT_RESET_CTRL_ADDR) begin
        next_ext_reset_pin_enable = wdata[`EXT_RESET_EN_BIT];
      end else if (addr == `CHANGE_STATUS_ADDR) begin
        if (!wdata[`CHANGE_FLAG_BIT]) begin
          next_port_change_flag = 1'b0;
        end
      end
    end
    if (rd_en) begin
      if (addr == `PORT_PIN_DATA_ADDR) begin
        next_rdata = {2'b00, port_view}; // RULE15
        next_last_read = port_view; // RULE18
      end else if (addr == `PIN_DIRECTION_ADDR) begin
        next_rdata = {2'b00, dir_view}; // RULE4
      end else if (addr == `PULLUP_SELECT_ADDR) begin
        next_rdata = {2'b00, pullup_select_bits};
      end else if (addr == `CHANGE_ENABLE_ADDR) begin
        next_rdata = {2'b00, change_detect_enables};
      end else if (addr == `ANALOG_SELECT_ADDR) begin
        next_rdata = {2'b00, analog_select_reg};
      end else if (addr == `OPTIONS_ADDR) begin
        next_rdata = options;
      end else if (addr == `EXT_RESET_CTRL_ADDR) begin
        next_rdata = {7'h00, ext_reset_pin_enable};
      end else if (addr == `CHANGE_STATUS_ADDR) begin
        next_rdata = {7'h00, port_change_flag};
      end
    end
    // set beats clear in the same cycle
    if (|mismatch) begin
      next_port_change_flag = 1'b1; // RULE18
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_latch <= 6'h00;
      pin_direction_bits <= `DIRECTION_RESET;
      pullup_select_bits <= `PULLUP_SELECT_RESET;
      change_detect_enables <= `CHANGE_ENABLE_RESET; // RULE19
      analog_select_reg <= `ANALOG_SELECT_RESET;
      options <= `OPTIONS_RESET; // RULE14
      ext_reset_pin_enable <= 1'b0;
      last_read <= 6'h00;
      port_change_flag <= 1'b0;
      rdata <= 8'h00;
    end else begin
      out_latch <= next_out_latch;
      pin_direction_bits <= next_pin_direction_bits;
      pullup_select_bits <= next_pullup_select_bits;
      change_detect_enables <= next_change_detect_enables;
      analog_select_reg <= next_analog_select_reg;
      options <= next_options;
      ext_reset_pin_enable <= next_ext_reset_pin_enable;
      last_read <= next_last_read;
      port_change_flag <= next_port_change_flag;
      rdata <= next_rdata;
    end
  end

  // assertions
  property p_out_drive;
    @(posedge clk) disable iff (!reset_n)
      !pin_direction_bits[0] |-> (pin_oe[0] && pin_out[0] == out_latch[0]);
  endproperty
  a_out_drive: assert property (p_out_drive) // RULE3
    else $error("output pin not driven from latch");

  property p_in_hiz;
    @(posedge clk) disable iff (!reset_n)
      pin_direction_bits[1] |-> !pin_oe[1];
  endproperty
  a_in_hiz: assert property (p_in_hiz) // RULE2
    else $error("input pin driven");

  property p_pin3_input;
    @(posedge clk) disable iff (!reset_n)
      rd_en && addr == `PIN_DIRECTION_ADDR |=> rdata[3] && rdata[7:6] == 2'b00;
  endproperty
  a_pin3_input: assert property (p_pin3_input) // RULE4
    else $error("input-only direction bit read wrong");

  property p_pin3_oe;
    @(posedge clk) disable iff (!reset_n) !pin_oe[3] && !pullup_en[3];
  endproperty
  a_pin3_oe: assert property (p_pin3_oe) // RULE12
    else $error("input-only pin driven or pulled");

  property p_ext_reset_zero;
    @(posedge clk) disable iff (!reset_n)
      rd_en && addr == `PORT_PIN_DATA_ADDR && ext_reset_pin_enable
        |=> !rdata[3];
  endproperty
  a_ext_reset_zero: assert property (p_ext_reset_zero) // RULE7
    else $error("reset-function pin read nonzero");

  property p_analog_zero;
    @(posedge clk) disable iff (!reset_n)
      rd_en && addr == `PORT_PIN_DATA_ADDR |=>
        (rdata[5:0] & $past(analog_select_reg)) == 6'h00
        && rdata[7:6] == 2'b00;
  endproperty
  a_analog_zero: assert property (p_analog_zero) // RULE10
    else $error("analog pin read nonzero");

  property p_pullup_off_out;
    @(posedge clk) disable iff (!reset_n)
      (!pin_direction_bits[2] || pullup_global_disable) |-> !pullup_en[2];
  endproperty
  a_pullup_off_out: assert property (p_pullup_off_out) // RULE13
    else $error("pull-up on while output or globally off");

  property p_pullup_follow;
    @(posedge clk) disable iff (!reset_n)
      !pullup_global_disable && pin_direction_bits[0]
        |-> pullup_en[0] == pullup_select_bits[0];
  endproperty
  a_pullup_follow: assert property (p_pullup_follow) // RULE17
    else $error("pull-up ignores select bit");

  sequence s_mismatch;
    |mismatch;
  endsequence
  property p_change_set;
    @(posedge clk) disable iff (!reset_n) s_mismatch |=> port_change_flag;
  endproperty
  a_change_set: assert property (p_change_set) // RULE18
    else $error("change flag not set on mismatch");

  property p_write_latch;
    @(posedge clk) disable iff (!reset_n)
      wr_en && addr == `PORT_PIN_DATA_ADDR |=> out_latch == $past(wdata[5:0]);
  endproperty
  a_write_latch: assert property (p_write_latch) // RULE6
    else $error("write did not reach output latch");

  // rdata stands one cycle only, then drops back to zero
  property p_rdata_idle;
    @(posedge clk) disable iff (!reset_n) !rd_en |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RULE15
    else $error("read data held past its cycle");

  // a data read shows the pin three edges back, through both flops
  sequence s_settled_read;
    rd_en && addr == `PORT_PIN_DATA_ADDR && !ext_reset_pin_enable
      && $past(reset_n) && $past(reset_n, 2);
  endsequence
  property p_sync_read;
    @(posedge clk) disable iff (!reset_n)
      s_settled_read |=>
        rdata[5:0] == ($past(pin_in, 3) & ~$past(analog_select_reg));
  endproperty
  a_sync_read: assert property (p_sync_read) // RULE20
    else $error("data read not taken from synchronised pins");

  // flag sticks until software writes a zero to it
  property p_flag_sticky;
    @(posedge clk) disable iff (!reset_n)
      port_change_flag && !(wr_en && addr == `CHANGE_STATUS_ADDR
        && !wdata[`CHANGE_FLAG_BIT]) |=> port_change_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // RULE18
    else $error("change flag dropped without a clear");

  // nothing but a data write may move the output latch
  property p_latch_hold;
    @(posedge clk) disable iff (!reset_n)
      !(wr_en && addr == `PORT_PIN_DATA_ADDR) |=> $stable(out_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // RULE5
    else $error("output latch moved without a data write");

  // with every enable clear no pin movement may raise the flag
  property p_change_quiet;
    @(posedge clk) disable iff (!reset_n)
      !port_change_flag && change_detect_enables == 6'h00
        |=> !port_change_flag;
  endproperty
  a_change_quiet: assert property (p_change_quiet) // RULE19
    else $error("change flag rose with detection disabled");
endmodule // six_pin_bidir_port
`default_nettype wire

/* testbench/pin_world.sv */
// pin-side model: outside drivers, weak pull-ups and floating lines
`timescale 1ns/10ps
`default_nettype none
module pin_world (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pullup_en,
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  output logic [5:0] pin_level
);
  logic [5:0] drift = 6'h15;
  // a floating line wanders so a stale level never passes for a read
  always @(posedge clk) begin
    drift <= ~drift;
  end
  // device driver wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pullup_en[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = drift[i];
    end
  end
endmodule // pin_world
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the six-pin port
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_regs.svh"
module tb;
  import gpio_port_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic clk, reset_n, wr_en, rd_en, port_change_flag;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] pin_in, pin_out, pin_oe, pullup_en, ext_val, ext_en;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // write then read back; analog cleared before digital use
  row_t rows[6] = '{'{`PIN_DIRECTION_ADDR, 8'h00, 8'h08},
    '{`PULLUP_SELECT_ADDR, 8'hff, 8'h37}, '{`CHANGE_ENABLE_ADDR, 8'hff, 8'h3f},
    '{`ANALOG_SELECT_ADDR, 8'h00, 8'h00},
    '{`OPTIONS_ADDR, 8'h7f, 8'h7f}, '{8'h40, 8'hff, 8'h00}};
  six_pin_bidir_port #(.PINS(6)) dut (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .port_change_flag(port_change_flag));
  pin_world world (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en),
    .pin_level(pin_in));
  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs are looked at mid-cycle, after every edge update has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // pins need the two synchroniser flops before a read sees them
  task automatic drive(input logic [5:0] v);
    @(posedge clk);
    ext_val <= v;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cut a hang short far beyond the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ext_val = 6'h08;
    ext_en = 6'h3f;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk({2'b00, pin_oe}, 8'h00);
    chk({2'b00, pullup_en}, 8'h00);
    chk({7'h00, port_change_flag}, 8'h00);
    rdchk(`OPTIONS_ADDR, 8'hff);
    rdchk(`PIN_DIRECTION_ADDR, 8'h3f);
    rdchk(`PULLUP_SELECT_ADDR, 8'h37);
    rdchk(`CHANGE_ENABLE_ADDR, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
    end
    chk({2'b00, pin_oe}, 8'h37);
    chk({2'b00, pullup_en}, 8'h00);
    // whole latch stored; pin 3 stays an input fed from outside
    wr(`PORT_PIN_DATA_ADDR, 8'h2a);
    chk({2'b00, pin_out}, 8'h22);
    drive(6'h08);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h2a);
    wr(`EXT_RESET_CTRL_ADDR, 8'h01);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h22);
    rdchk(`EXT_RESET_CTRL_ADDR, 8'h01);
    // read data must fall back to zero one cycle later
    @(negedge clk);
    chk(rdata, 8'h00);
    wr(`EXT_RESET_CTRL_ADDR, 8'h00);
    // analog pin 1 left as output on purpose
    wr(`ANALOG_SELECT_ADDR, 8'h02);
    chk({2'b00, pin_oe}, 8'h37);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h28);
    wr(`ANALOG_SELECT_ADDR, 8'h00);
    wr(`PIN_DIRECTION_ADDR, 8'h3f);
    chk({2'b00, pin_oe}, 8'h00);
    chk({2'b00, pin_out}, 8'h00);
    chk({2'b00, pullup_en}, 8'h37);
    drive(6'h15);
    // analog pin 2 kept an input while selected, as software must
    wr(`ANALOG_SELECT_ADDR, 8'h04);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h11);
    wr(`ANALOG_SELECT_ADDR, 8'h00);
    wr(`PORT_PIN_DATA_ADDR, 8'h3d);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h15);
    wr(`PIN_DIRECTION_ADDR, 8'h3e);
    chk({2'b00, pin_out}, 8'h01);
    chk({2'b00, pullup_en}, 8'h36);
    wr(`OPTIONS_ADDR, 8'hff);
    chk({2'b00, pullup_en}, 8'h00);
    // change detection: relatch, clear, then move pin 5
    rdchk(`PORT_PIN_DATA_ADDR, 8'h15);
    wr(`CHANGE_STATUS_ADDR, 8'h00);
    chk({7'h00, port_change_flag}, 8'h00);
    drive(6'h35);
    chk({7'h00, port_change_flag}, 8'h01);
    rdchk(`CHANGE_STATUS_ADDR, 8'h01);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h35);
    wr(`CHANGE_STATUS_ADDR, 8'h00);
    chk({7'h00, port_change_flag}, 8'h00);
    wr(`CHANGE_ENABLE_ADDR, 8'h1f);
    drive(6'h15);
    chk({7'h00, port_change_flag}, 8'h00);
    // released pin 4 must read high on its pull-up, not the float
    wr(`OPTIONS_ADDR, 8'h7f);
    @(posedge clk);
    ext_en <= 6'h2f;
    drive(6'h05);
    rdchk(`PORT_PIN_DATA_ADDR, 8'h15);
    drive(6'h05); // odd cycle count so the float is caught at both phases
    rdchk(`PORT_PIN_DATA_ADDR, 8'h15);
    // mid-run reset brings back the power-up configuration
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk({2'b00, pin_oe}, 8'h00);
    chk({2'b00, pullup_en}, 8'h00);
    chk({7'h00, port_change_flag}, 8'h00);
    rdchk(`OPTIONS_ADDR, 8'hff);
    rdchk(`PIN_DIRECTION_ADDR, 8'h3f);
    rdchk(`CHANGE_ENABLE_ADDR, 8'h00);
    close_out();
  end
endmodule // tb
`default_nettype wire
